// *** include/dch_tap_pkg.sv ***
/*
  Constants for the D channel monitor tap: register indices, field positions,
  reset values, stream sizes and slot codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses of 18 bits.
*/
package dch_tap_pkg;
  localparam int          ADDR_W         = 18;
  localparam int          DATA_W         = 32;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_MONITOR    = 16'hffd1;
  localparam logic [15:0] IDX_TRANSMIT   = 16'hffd2;
  localparam logic [15:0] IDX_ROUTING    = 16'hffe0;
  localparam logic [15:0] IDX_TXBUF_LO   = 16'hffe1;
  localparam logic [15:0] IDX_TXBUF_HI   = 16'hffe2;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hffe3;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hffe4;
  localparam logic [15:0] IDX_STATUS     = 16'hffe5;
  // field positions
  localparam int          MON_SCOPE_BIT  = 0;
  localparam int          MON_DIR_BIT    = 1;
  localparam int          TX_CONT_BIT    = 0;
  localparam int          TX_LATE_BIT    = 1;
  localparam int          ROUTE_LSB      = 5;
  localparam int          ROUTE_MSB      = 6;
  localparam logic [1:0]  ROUTE_D_IO     = 2'h2;
  localparam int          IRQ_EMPTY_BIT  = 0;
  localparam int          IRQ_WORD_BIT   = 1;
  localparam int          IRQ_W          = 2;
  localparam int          ST_BYTE_LSB    = 0;
  localparam int          ST_FULL_BIT    = 3;
  localparam int          ST_WORD_BIT    = 4;
  localparam int          ST_GAP_BIT     = 5;
  localparam int          ST_ROUTE_BIT   = 6;
  // reset values
  localparam logic [1:0]  MONITOR_RST    = 2'h0;
  localparam logic [1:0]  TRANSMIT_RST   = 2'h0;
  localparam logic [7:0]  ROUTING_RST    = 8'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  // stream sizes
  localparam int          BUF_BYTES      = 6;
  localparam logic [2:0]  LAST_BYTE      = 3'h5;
  localparam logic [2:0]  BYTES_DONE     = 3'h6;
  localparam logic [5:0]  PARITY_SLOT    = 6'h30;
  localparam logic [5:0]  IDLE_LAST      = 6'h2f;
  localparam logic [2:0]  BYTE_END       = 3'h7;
  // idle fill pattern, value arbitrary
  localparam logic [47:0] IDLE_PATTERN   = 48'haaaa_aaaa_aaaa;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // bit class of the current radio bit, as told by the formatter
  typedef enum logic [1:0] {
    SLOT_PREAMBLE = 2'h0,
    SLOT_SYN      = 2'h1,
    SLOT_B        = 2'h2,
    SLOT_D        = 2'h3
  } slot_e;
endpackage : dch_tap_pkg

// *** logic/dch_byte_shifter.sv ***
/*
  Byte-wide serializer for D channel code words, msb first, with a running
  parity over every bit shifted out.
  Assumes load and shift are single-cycle strobes from the owner.
*/
`timescale 1ns/1ps
module dch_byte_shifter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       load,
  input  wire logic       first,
  input  wire logic [7:0] load_byte,
  input  wire logic       shift,
  output logic            bit_out,
  output logic            parity
);
  import dch_tap_pkg::*;

  logic [7:0] shreg_r;
  logic       par_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_r <= BYTE_RST;
    end else if (load) begin
      shreg_r <= load_byte;
    end else if (shift) begin
      shreg_r <= {shreg_r[6:0], 1'b0};
    end
  end

  // a shift in the load cycle still counts the outgoing bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_r <= 1'b0;
    end else if (first) begin
      par_r <= 1'b0;
    end else if (shift) begin
      par_r <= par_r ^ shreg_r[7];
    end
  end

  assign bit_out = shreg_r[7];
  assign parity  = par_r;
endmodule : dch_byte_shifter

// *** logic/tap_slot_filter.sv ***
/*
  Decides whether the current radio bit belongs on the tap pins.
  Assumes the slot class is valid whenever bit_tick is high.
*/
`timescale 1ns/1ps
module tap_slot_filter (
  input  wire dch_tap_pkg::slot_e slot,
  input  wire logic               wide_scope,
  output logic                    qualify
);
  import dch_tap_pkg::*;

  always_comb begin
    unique case (slot)
      SLOT_D:        qualify = 1'b1;
      SLOT_B:        qualify = wide_scope;
      SLOT_SYN:      qualify = wide_scope;
      SLOT_PREAMBLE: qualify = 1'b0;
    endcase
  end
endmodule : tap_slot_filter

// *** logic/dchannel_monitor_tap.sv ***
/*
  D channel test and monitor tap with the D channel transmit serializer
  and its AXI4-Lite register file.
  Assumes the formatter gives one bit_tick per radio bit with the slot class,
  its own SYN/B bits, the received bit and a word_start strobe.
*/
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module dchannel_monitor_tap (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [dch_tap_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dch_tap_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       bit_tick,
  input  wire dch_tap_pkg::slot_e         slot_type,
  input  wire logic                       word_start,
  input  wire logic                       tx_mux2,
  input  wire logic                       fmt_tx_bit,
  input  wire logic                       radio_rx_bit,
  output logic                            radio_tx_bit,
  input  wire logic                       tx_tap_pin_i,
  output logic                            tx_tap_pin_o,
  output logic                            tx_tap_pin_oe_n,
  output logic                            rx_tap_pin_o,
  output logic                            rx_tap_pin_oe_n,
  output logic                            irq
);
  import dch_tap_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WORD, ST_GAP} tx_state_e;

  // bus side
  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  logic [1:0]           rresp_r;
  logic [15:0]          aw_idx_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 wr_do;
  logic [15:0]          ar_idx;
  logic [31:0]          rd_mux;
  // registers
  logic [1:0]           monitor_r;
  logic [1:0]           transmit_r;
  logic [7:0]           routing_r;
  logic [7:0]           tx_buf_r [BUF_BYTES];
  logic                 buf_full_r;
  logic [IRQ_W-1:0]     irq_status_r;
  logic [IRQ_W-1:0]     irq_mask_r;
  logic [IRQ_W-1:0]     irq_set;
  logic [IRQ_W-1:0]     irq_clr;
  logic [IRQ_W-1:0]     irq_status_nxt;
  // transmit path
  tx_state_e            state_r;
  logic [2:0]           byte_idx_r;
  logic [5:0]           bit_cnt_r;
  logic [5:0]           gap_cnt_r;
  logic [5:0]           idle_idx_r;
  logic                 d_tick;
  logic                 word_tick;
  logic                 start_word;
  logic                 load_next;
  logic                 sh_load;
  logic                 sh_shift;
  logic [7:0]           sh_byte;
  logic                 sh_bit;
  logic                 sh_parity;
  logic                 last_byte_ev;
  logic                 parity_done;
  logic                 empty_ev;
  logic                 d_bit;
  logic                 idle_bit;
  // tap path
  logic                 route_on;
  logic                 scope_wide;
  logic                 tap_in_mode;
  logic                 qualify;
  logic                 inject;
  logic                 own_tx_bit;
  logic                 sent_bit;
  logic                 radio_tx_r;
  logic                 tx_tap_o_r;
  logic                 tx_tap_oe_n_r;
  logic                 rx_tap_o_r;
  logic                 rx_tap_oe_n_r;
  logic                 irq_r;

  function automatic logic idx_mapped(input logic [15:0] idx);
    idx_mapped = (idx == IDX_MONITOR)    || (idx == IDX_TRANSMIT) ||
                 (idx == IDX_ROUTING)    || (idx == IDX_TXBUF_LO) ||
                 (idx == IDX_TXBUF_HI)   || (idx == IDX_IRQ_STATUS) ||
                 (idx == IDX_IRQ_MASK)   || (idx == IDX_STATUS);
  endfunction : idx_mapped

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_idx_r  <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_idx_r  <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_do) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_do) begin
      wready_r <= 1'b1;
    end
  end

  assign wr_do = !awready_r && !wready_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= idx_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel: one beat, answered the cycle after the address
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_mux = '0;
    unique case (ar_idx)
      IDX_MONITOR:    rd_mux[1:0] = monitor_r;
      IDX_TRANSMIT:   rd_mux[1:0] = transmit_r;
      IDX_ROUTING:    rd_mux[7:0] = routing_r;
      IDX_TXBUF_LO:   rd_mux = {tx_buf_r[3], tx_buf_r[2], tx_buf_r[1], tx_buf_r[0]};
      IDX_TXBUF_HI:   rd_mux[15:0] = {tx_buf_r[5], tx_buf_r[4]};
      IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_r;
      IDX_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_r;
      IDX_STATUS: begin
        rd_mux[ST_BYTE_LSB +: 3] = byte_idx_r;
        rd_mux[ST_FULL_BIT]      = buf_full_r;
        rd_mux[ST_WORD_BIT]      = (state_r == ST_WORD);
        rd_mux[ST_GAP_BIT]       = (state_r == ST_GAP);
        rd_mux[ST_ROUTE_BIT]     = route_on;
      end
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // configuration registers, byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_r  <= MONITOR_RST;
      transmit_r <= TRANSMIT_RST;
      routing_r  <= ROUTING_RST;
      irq_mask_r <= '0;
    end else if (wr_do && wstrb_r[0]) begin
      if (aw_idx_r == IDX_MONITOR) begin
        monitor_r <= wdata_r[1:0];
      end
      if (aw_idx_r == IDX_TRANSMIT) begin
        transmit_r <= wdata_r[1:0];
      end
      if (aw_idx_r == IDX_ROUTING) begin
        routing_r <= wdata_r[7:0];
      end
      if (aw_idx_r == IDX_IRQ_MASK) begin
        irq_mask_r <= wdata_r[IRQ_W-1:0];
      end
    end
  end

  // six-byte transmit buffer, bytes 0..3 in the low word, 4..5 in the high
  for (genvar i = 0; i < BUF_BYTES; i++) begin : g_buf
    localparam logic [15:0] WORD_IDX = (i < 4) ? IDX_TXBUF_LO : IDX_TXBUF_HI;
    localparam int          LANE     = i % 4;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tx_buf_r[i] <= BYTE_RST;
      end else if (wr_do && (aw_idx_r == WORD_IDX) && wstrb_r[LANE]) begin
        tx_buf_r[i] <= wdata_r[LANE*8 +: 8];
      end
    end
  end

  // writing the high word marks the buffer loaded; a load beats the drain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_full_r <= 1'b0;
    end else if (wr_do && (aw_idx_r == IDX_TXBUF_HI)) begin
      buf_full_r <= 1'b1;
    end else if (empty_ev) begin
      buf_full_r <= 1'b0;
    end
  end

  // transmit sequencing
  assign d_tick    = bit_tick && (slot_type == SLOT_D);
  assign word_tick = d_tick && (state_r == ST_WORD);
  assign parity_done = word_tick && (bit_cnt_r == PARITY_SLOT);
  assign load_next = word_tick && (bit_cnt_r != PARITY_SLOT) &&
                     (bit_cnt_r[2:0] == BYTE_END) && (byte_idx_r != BYTES_DONE);
  // continuous words restart back to back, or after the idle gap in mux 2
  assign start_word = ((state_r == ST_IDLE) && buf_full_r && word_start) ||
                      (parity_done && transmit_r[TX_CONT_BIT] && !tx_mux2) ||
                      ((state_r == ST_GAP) && d_tick && (gap_cnt_r == IDLE_LAST));
  assign sh_load  = start_word || load_next;
  assign sh_byte  = start_word ? tx_buf_r[0] : tx_buf_r[byte_idx_r];
  assign sh_shift = word_tick && (bit_cnt_r != PARITY_SLOT);
  assign last_byte_ev = load_next && (byte_idx_r == LAST_BYTE);
  assign empty_ev = !transmit_r[TX_CONT_BIT] &&
                    (transmit_r[TX_LATE_BIT] ? parity_done : last_byte_ev);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else if (start_word) begin
      state_r <= ST_WORD;
    end else if (parity_done) begin
      state_r <= (transmit_r[TX_CONT_BIT] && tx_mux2) ? ST_GAP : ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_idx_r <= '0;
      bit_cnt_r  <= '0;
    end else if (start_word) begin
      byte_idx_r <= 3'h1;
      bit_cnt_r  <= '0;
    end else if (word_tick) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
      if (load_next) begin
        byte_idx_r <= byte_idx_r + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_cnt_r <= '0;
    end else if (parity_done) begin
      gap_cnt_r <= '0;
    end else if ((state_r == ST_GAP) && d_tick) begin
      gap_cnt_r <= gap_cnt_r + 6'h01;
    end
  end

  // idle fill walks the pattern on every D bit outside a code word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_idx_r <= '0;
    end else if (start_word || parity_done) begin
      idle_idx_r <= '0;
    end else if (d_tick && (state_r != ST_WORD)) begin
      idle_idx_r <= (idle_idx_r == IDLE_LAST) ? 6'h00 : idle_idx_r + 6'h01;
    end
  end

  assign idle_bit = IDLE_PATTERN[IDLE_LAST - idle_idx_r];
  assign d_bit = (state_r != ST_WORD) ? idle_bit :
                 (bit_cnt_r == PARITY_SLOT) ? sh_parity : sh_bit;

  dch_byte_shifter u_shifter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (sh_load),
    .first     (start_word),
    .load_byte (sh_byte),
    .shift     (sh_shift),
    .bit_out   (sh_bit),
    .parity    (sh_parity)
  );

  // tap routing
  assign route_on    = (routing_r[ROUTE_MSB:ROUTE_LSB] == ROUTE_D_IO);
  assign scope_wide  = monitor_r[MON_SCOPE_BIT];
  assign tap_in_mode = route_on && monitor_r[MON_DIR_BIT];

  tap_slot_filter u_filter (
    .slot       (slot_type),
    .wide_scope (scope_wide),
    .qualify    (qualify)
  );

  assign own_tx_bit = (slot_type == SLOT_D) ? d_bit : fmt_tx_bit;
  assign inject     = tap_in_mode && qualify;
  assign sent_bit   = inject ? tx_tap_pin_i : own_tx_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      radio_tx_r <= 1'b0;
    end else if (bit_tick) begin
      radio_tx_r <= sent_bit;
    end
  end

  // tap outputs follow the radio bit; out-of-scope bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_tap_o_r <= 1'b0;
      rx_tap_o_r <= 1'b0;
    end else if (!route_on) begin
      tx_tap_o_r <= 1'b0;
      rx_tap_o_r <= 1'b0;
    end else if (bit_tick) begin
      tx_tap_o_r <= qualify && !tap_in_mode && sent_bit;
      rx_tap_o_r <= qualify && radio_rx_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_tap_oe_n_r <= 1'b1;
      rx_tap_oe_n_r <= 1'b1;
    end else begin
      tx_tap_oe_n_r <= !(route_on && !monitor_r[MON_DIR_BIT]);
      rx_tap_oe_n_r <= !route_on;
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  assign irq_set[IRQ_EMPTY_BIT] = empty_ev;
  assign irq_set[IRQ_WORD_BIT]  = parity_done;
  assign irq_clr = (wr_do && (aw_idx_r == IDX_IRQ_STATUS) && wstrb_r[0]) ?
                   wdata_r[IRQ_W-1:0] : '0;
  assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
      irq_r        <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_r        <= |(irq_status_r & irq_mask_r);
    end
  end

  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign radio_tx_bit    = radio_tx_r;
  assign tx_tap_pin_o    = tx_tap_o_r;
  assign tx_tap_pin_oe_n = tx_tap_oe_n_r;
  assign rx_tap_pin_o    = rx_tap_o_r;
  assign rx_tap_pin_oe_n = rx_tap_oe_n_r;
  assign irq             = irq_r;
endmodule : dchannel_monitor_tap

// *** bench/tap_equipment.sv ***
/*
  Far-side model of the tx tap pin: test gear that injects bits when asked.
  Assumes the device releases the pin by raising dev_oe_n.
*/
`timescale 1ns/1ps
module tap_equipment (
  input  wire logic aclk,
  input  wire logic inject,
  input  wire logic dev_oe_n,
  input  wire logic dev_o,
  output logic      pin
);
  logic drv_r;
  // no pull on this pin: when idle the gear shows the inverse of the last level
  always_ff @(posedge aclk) begin
    if (inject)
      drv_r <= 1'($urandom);
    else
      drv_r <= ~pin;
  end
  assign pin = !dev_oe_n ? dev_o : drv_r;
endmodule : tap_equipment

// *** bench/dch_tap_properties.sv ***
/*
  Concurrent checks on the monitor tap top-level ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module dch_tap_properties (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               bit_tick,
  input wire dch_tap_pkg::slot_e slot_type,
  input wire logic               radio_rx_bit,
  input wire logic               radio_tx_bit,
  input wire logic               tx_tap_pin_i,
  input wire logic               tx_tap_pin_o,
  input wire logic               tx_tap_pin_oe_n,
  input wire logic               rx_tap_pin_o,
  input wire logic               rx_tap_pin_oe_n
);
  import dch_tap_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic d_tick;
  assign d_tick = bit_tick && slot_type == SLOT_D;
  // oe_n lags the registers by one clock, so settings are checked on both sides of the tick
  property p_off_quiet; rx_tap_pin_oe_n && $past(rx_tap_pin_oe_n) |-> !rx_tap_pin_o && !tx_tap_pin_o; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("tap output active with routing off");
  property p_preamble; bit_tick && slot_type == SLOT_PREAMBLE |=> !rx_tap_pin_o && !tx_tap_pin_o; endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bit on a tap");
  property p_rx_copy; (d_tick && !rx_tap_pin_oe_n) ##1 !rx_tap_pin_oe_n |-> rx_tap_pin_o == $past(radio_rx_bit);
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("rx tap lost a d bit");
  property p_tx_copy; (d_tick && !tx_tap_pin_oe_n) ##1 !tx_tap_pin_oe_n |-> tx_tap_pin_o == radio_tx_bit; endproperty
  a_tx_copy: assert property (p_tx_copy) else $error("tx tap differs from sent bit");
  property p_inject; (d_tick && tx_tap_pin_oe_n && !rx_tap_pin_oe_n) ##1 (tx_tap_pin_oe_n && !rx_tap_pin_oe_n)
    |-> radio_tx_bit == $past(tx_tap_pin_i); endproperty
  a_inject: assert property (p_inject) else $error("injected bit not sent");
  property p_tx_hold; !bit_tick |=> $stable(radio_tx_bit); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("sent bit moved without a tick");
  property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |=> ##1 s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
endmodule : dch_tap_properties
bind dchannel_monitor_tap dch_tap_properties i_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .bit_tick, .slot_type, .radio_rx_bit, .radio_tx_bit,
  .tx_tap_pin_i, .tx_tap_pin_o, .tx_tap_pin_oe_n, .rx_tap_pin_o, .rx_tap_pin_oe_n);

// *** bench/tb_dchannel_monitor_tap.sv ***
/*
  Self-checking bench for the D channel monitor tap.
  Assumes package, design, checker and tap model are compiled first.
*/
`timescale 1ns/1ps
module tb_dchannel_monitor_tap;
  import dch_tap_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq;
  logic              awready, wready, bvalid, arready, rvalid, inject, pin_s, f_s, r_s;
  logic              bit_tick, word_start, tx_mux2, fmt_tx_bit, radio_rx_bit, radio_tx_bit;
  logic              pin, txo, tx_oe_n, rxo, rx_oe_n;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, rsp;
  logic [48:0]       got;
  slot_e             slot_type;
  int                n_fail, n_tests;

  dchannel_monitor_tap i_dut (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bit_tick, .slot_type, .word_start, .tx_mux2,
    .fmt_tx_bit, .radio_rx_bit, .radio_tx_bit, .tx_tap_pin_i(pin), .tx_tap_pin_o(txo),
    .tx_tap_pin_oe_n(tx_oe_n), .rx_tap_pin_o(rxo), .rx_tap_pin_oe_n(rx_oe_n), .irq);
  tap_equipment i_eq (.aclk, .inject, .dev_oe_n(tx_oe_n), .dev_o(txo), .pin);

  function automatic logic qual(input slot_e s, input logic wide);
    return s == SLOT_D || (wide && s != SLOT_PREAMBLE);
  endfunction : qual

  task automatic chk(input logic [48:0] seen, input logic [48:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // ready and answers are registered, so sampling on the falling edge is race free
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic a, w, b;
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      a   = awvalid & awready;
      w   = wvalid & wready;
      b   = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    logic a, v;
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      a   = arvalid & arready;
      v   = rvalid;
      d   = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
  endtask : rd

  task automatic tk(input slot_e s);
    @(posedge aclk);
    bit_tick     <= 1'b1;
    slot_type    <= s;
    fmt_tx_bit   <= 1'($urandom);
    radio_rx_bit <= 1'($urandom);
    @(negedge aclk);
    pin_s = pin;
    f_s   = fmt_tx_bit;
    r_s   = radio_rx_bit;
    @(posedge aclk);
    bit_tick <= 1'b0;
    @(negedge aclk);
    got = {got[47:0], radio_tx_bit};
  endtask : tk

  task automatic st(input logic e, input logic msk);
    logic [31:0] d;
    rd(IDX_IRQ_STATUS, d);
    chk(d[IRQ_EMPTY_BIT], e);
    chk(irq, e && msk);
  endtask : st

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    #400000;
    n_fail++;
    conclude;
  end

  initial begin
    logic [31:0] d;
    logic [47:0] data;
    logic [7:0]  r;
    logic [1:0]  mon;
    logic        q, route;
    slot_e       s;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bit_tick, word_start, tx_mux2, inject} = '0;
    {awaddr, araddr, wdata, fmt_tx_bit, radio_rx_bit, got, n_fail, n_tests} = '0;
    slot_type = SLOT_PREAMBLE;
    void'($urandom(32'h1f2c));
    do_reset;
    rd(IDX_MONITOR, d);
    chk(d, {30'h0, MONITOR_RST});
    rd(IDX_TRANSMIT, d);
    chk(d, {30'h0, TRANSMIT_RST});
    wr(IDX_TRANSMIT, 32'hffff_fffc);
    chk(rsp, RESP_OKAY);
    rd(IDX_TRANSMIT, d);
    chk(d, 32'h0);
    rd(16'h0001, d);
    chk({rsp, d}, {RESP_SLVERR, 32'h0});
    wr(16'h0001, 32'h3);
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < 60; i++) begin
      r   = 8'($urandom);
      mon = 2'($urandom);
      s   = slot_e'(2'($urandom));
      // forced corners: routing on, D bits, every monitor mode
      if (i < 4) begin
        r[ROUTE_MSB:ROUTE_LSB] = ROUTE_D_IO;
        mon                    = 2'(i);
        s                      = SLOT_D;
      end
      wr(IDX_ROUTING, {24'h0, r});
      wr(IDX_MONITOR, {30'h0, mon});
      inject <= mon[MON_DIR_BIT];
      tk(s);
      route = r[ROUTE_MSB:ROUTE_LSB] == ROUTE_D_IO;
      q     = route && qual(s, mon[MON_SCOPE_BIT]);
      chk(rxo, q ? r_s : 1'b0);
      chk({tx_oe_n, rx_oe_n}, {!(route && !mon[MON_DIR_BIT]), !route});
      if (s != SLOT_D)
        chk(radio_tx_bit, (q && mon[MON_DIR_BIT]) ? pin_s : f_s);
      if (s != SLOT_D && !mon[MON_DIR_BIT])
        chk(txo, q ? f_s : 1'b0);
    end
    // m bit 1 picks late empty flag and mux 2, bit 0 continuous mode
    for (int m = 0; m < 4; m++) begin
      do_reset;
      data = {16'($urandom), $urandom};
      tx_mux2 <= m[1];
      wr(IDX_IRQ_MASK, {31'h0, m != 0});
      wr(IDX_TRANSMIT, 32'(m));
      wr(IDX_TXBUF_LO, {data[23:16], data[31:24], data[39:32], data[47:40]});
      wr(IDX_TXBUF_HI, {16'h0, data[7:0], data[15:8]});
      @(posedge aclk);
      word_start <= 1'b1;
      @(posedge aclk);
      word_start <= 1'b0;
      repeat (44) tk(SLOT_D);
      st(m == 0, m != 0);
      repeat (4) tk(SLOT_D);
      st(m == 0, m != 0);
      tk(SLOT_D);
      chk(got, {data, ^data});
      st(!m[0], m != 0);
      repeat (48) tk(SLOT_D);
      chk(got[47:0], m == 1 ? data : IDLE_PATTERN);
      st(!m[0], m != 0);
      wr(IDX_IRQ_STATUS, 32'h3);
      st(1'b0, m != 0);
    end
    conclude;
  end
endmodule : tb_dchannel_monitor_tap
